/* inc/srsb_defs.svh */
// Offsets, field positions, reset values and timing for the status byte
`ifndef SRSB_DEFS_SVH
`define SRSB_DEFS_SVH
`define SRSB_BIT_PROC 3'h0
`define SRSB_BIT_ERR 3'h1
`define SRSB_BIT_GAUGE 3'h2
`define SRSB_BIT_UNUSED 3'h3
`define SRSB_BIT_MAV 3'h4
`define SRSB_BIT_EVENT 3'h5
`define SRSB_BIT_SRQ 3'h6
`define SRSB_BIT_IDLE 3'h7
`define SRSB_SRE_RST 8'h00
`define SRSB_PSC_RST 1'h0
`define SRSB_KEEP_RST 40'h00_0000_0000
`define SRSB_SRQ_MASK 8'hbf
`define SRSB_ANSWER_CYCLES 1
`endif

/* inc/srsb_pkg.sv */
// Types shared by the status byte block and its helpers
package srsb_pkg;
    typedef logic [7:0] srsb_word_t;
    typedef logic [2:0] srsb_idx_t;
    // One lower status register with its enable register
    typedef struct packed {
        srsb_word_t stat;
        srsb_word_t en;
    } srsb_lower_s;
    // Status byte query: whole byte, or one bit by index
    typedef struct packed {
        logic valid;
        logic single;
        srsb_idx_t idx;
    } srsb_query_s;
    // Service request enable write: whole byte or one bit
    typedef struct packed {
        logic valid;
        logic single;
        srsb_idx_t idx;
        logic bit_val;
        srsb_word_t value;
    } srsb_sre_cmd_s;
    // The four lower enable registers as one group
    typedef struct packed {
        srsb_word_t proc_en;
        srsb_word_t err_en;
        srsb_word_t gauge_en;
        srsb_word_t event_en;
    } srsb_en_set_s;
    // Power sequencing states
    typedef enum logic [2:0] {
        SRSB_RUN = 3'b001,
        SRSB_LOAD = 3'b010,
        SRSB_SETTLE = 3'b100
    } srsb_pwr_e;
endpackage

/* verilog/srsb_sum.sv */
// Summary bit of one lower status register: any enabled bit set
`timescale 1ns/1ps
module srsb_sum #(
    parameter int WIDTH = 8
) (
    // Lower register and its enable
    input wire logic [WIDTH-1:0] stat,
    input wire logic [WIDTH-1:0] en,
    // Summary out
    output logic summary
);
    generate
        if (WIDTH < 1 || WIDTH > 16) begin : g_bad
            $error("srsb_sum width out of range");
        end
    endgenerate

    // Pure level: follows the register and its enable, so it clears with either
    assign summary = |(stat & en);
endmodule

/* verilog/srsb_keep.sv */
// Retention store for enable registers across power cycles
`timescale 1ns/1ps
`include "srsb_defs.svh"
module srsb_keep #(
    parameter int WIDTH = 40
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Save strobe and data
    input wire logic save,
    input wire logic [WIDTH-1:0] save_val,
    // Saved copy
    output logic [WIDTH-1:0] kept_q
);
    generate
        if (WIDTH != 40) begin : g_bad
            $error("srsb_keep holds exactly five enable bytes");
        end
    endgenerate

    // Stands in for battery-backed storage; only rst wipes it
    always_ff @(posedge core_clk) begin
        if (rst) begin
            kept_q <= `SRSB_KEEP_RST;
        end else if (save) begin
            kept_q <= save_val;
        end
    end
endmodule

/* verilog/srsb_top.sv */
// Status byte, service request logic and enable retention
// Contract
// - Flag 0: save enables at power-down; power-up clears status, reloads enables.
// - Restored enables let a request rise right after power-up.
// - Whole-byte query returns all eight status bits, 0 to 255.
// - Single-bit query with index 0-7 returns just that bit.
// - Bit 0 set while any enabled process-control status bit is set.
// - Bit 1 set while any enabled error status bit is set.
// - Bit 2 set while any enabled gauge status bit is set.
// - Bit 4 set while the output buffer holds unread response data.
// - Bit 5 set while any enabled standard event status bit is set.
// - Bit 7 set when idle, clear while a command executes.
// - Queried bit 6 is one when status and request enable share a bit.
// - Queried bit 6 ignores polls and requests; poll bit 6 means request.
// - Querying the byte changes nothing in it.
// - A bit stays set while its cause lasts, clears with the cause.
// - One request per 0-to-1 change of an enabled bit, never repeated.
// - First poll after a request shows bit 6 set, then it clears.
// - Clear-status clears status registers, leaves enables unchanged.
`timescale 1ns/1ps
`include "srsb_defs.svh"
module srsb_top (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Lower status registers with enables
    input wire srsb_pkg::srsb_lower_s proc_reg,
    input wire srsb_pkg::srsb_lower_s err_reg,
    input wire srsb_pkg::srsb_lower_s gauge_reg,
    input wire srsb_pkg::srsb_lower_s event_reg,
    // Output buffer and execution state
    input wire logic out_buf_has_data,
    input wire logic cmd_busy,
    // Host commands
    input wire srsb_pkg::srsb_sre_cmd_s request_enable_command,
    input wire logic power_on_clear_command,
    input wire logic power_on_clear_value,
    input wire logic clear_status_command,
    input wire srsb_pkg::srsb_query_s status_byte_query,
    input wire logic serial_poll,
    // Power events
    input wire logic power_down,
    input wire logic power_up,
    // Query answer
    output srsb_pkg::srsb_word_t query_data,
    output logic query_valid,
    // Serial poll answer and request line
    output srsb_pkg::srsb_word_t poll_data,
    output logic poll_valid,
    output logic srq_pending,
    // Register views
    output srsb_pkg::srsb_word_t service_status_byte,
    output srsb_pkg::srsb_word_t request_enable_q,
    output logic power_on_clear_flag,
    // Controls toward lower status registers
    output logic status_clear,
    output logic en_load,
    output srsb_pkg::srsb_en_set_s en_load_val
);
    import srsb_pkg::*;

    srsb_word_t stb;
    srsb_word_t enabled_bits;
    srsb_word_t prev_q;
    logic proc_summary_bit;
    logic error_summary_bit;
    logic gauge_summary_bit;
    logic event_summary_bit;
    logic new_request;
    logic [39:0] kept_q;
    srsb_en_set_s live_en;
    srsb_pwr_e pwr_q;
    logic status_clear_q;
    logic en_load_q;
    srsb_en_set_s en_load_val_q;

    // Bit of a byte picked by index; used by the single-bit query
    function automatic logic pick_bit(srsb_word_t b, srsb_idx_t i);
        pick_bit = b[i];
    endfunction

    // Request-bit value seen by a query
    function automatic logic query_srq(srsb_word_t b, srsb_word_t e);
        query_srq = |(b & e & `SRSB_SRQ_MASK);
    endfunction

    // Summary bits; levels, so they clear with their causes
    srsb_sum #(.WIDTH(8)) u_sum_proc (
        .stat(proc_reg.stat),
        .en(proc_reg.en),
        .summary(proc_summary_bit)
    );
    srsb_sum #(.WIDTH(8)) u_sum_err (
        .stat(err_reg.stat),
        .en(err_reg.en),
        .summary(error_summary_bit)
    );
    srsb_sum #(.WIDTH(8)) u_sum_gauge (
        .stat(gauge_reg.stat),
        .en(gauge_reg.en),
        .summary(gauge_summary_bit)
    );
    srsb_sum #(.WIDTH(8)) u_sum_event (
        .stat(event_reg.stat),
        .en(event_reg.en),
        .summary(event_summary_bit)
    );

    // Live status byte; bit 6 is the query view
    always_comb begin
        stb = 8'h00;
        stb[`SRSB_BIT_PROC] = proc_summary_bit;
        stb[`SRSB_BIT_ERR] = error_summary_bit;
        stb[`SRSB_BIT_GAUGE] = gauge_summary_bit;
        stb[`SRSB_BIT_UNUSED] = 1'b0;
        stb[`SRSB_BIT_MAV] = out_buf_has_data;
        stb[`SRSB_BIT_EVENT] = event_summary_bit;
        stb[`SRSB_BIT_IDLE] = ~cmd_busy;
        stb[`SRSB_BIT_SRQ] = query_srq(stb, request_enable_q);
    end
    assign service_status_byte = stb;

    // Bit 6 is excluded so a request cannot feed itself
    assign enabled_bits = stb & request_enable_q & `SRSB_SRQ_MASK;
    assign new_request = |(enabled_bits & ~prev_q);

    // Previous enabled bits; zeroed at load so can fire at once
    always_ff @(posedge core_clk) begin
        if (rst || en_load_q) begin
            prev_q <= 8'h00;
        end else begin
            prev_q <= enabled_bits;
        end
    end

    // Pending request: a new edge wins over a poll or a clear
    always_ff @(posedge core_clk) begin
        if (rst) begin
            srq_pending <= 1'b0;
        end else if (new_request) begin
            srq_pending <= 1'b1;
        end else if (serial_poll || status_clear_q) begin
            srq_pending <= 1'b0;
        end
    end

    // Serial poll answer carries the pending request as bit 6
    always_ff @(posedge core_clk) begin
        if (rst) begin
            poll_data <= 8'h00;
            poll_valid <= 1'b0;
        end else begin
            poll_valid <= serial_poll;
            if (serial_poll) begin
                poll_data <= {stb[7], srq_pending, stb[5:0]};
            end
        end
    end

    // Query answer; reads only, nothing is cleared by it
    always_ff @(posedge core_clk) begin
        if (rst) begin
            query_data <= 8'h00;
            query_valid <= 1'b0;
        end else begin
            query_valid <= status_byte_query.valid;
            if (status_byte_query.valid && status_byte_query.single) begin
                query_data <= {7'h00, pick_bit(stb,
                    status_byte_query.idx)};
            end else if (status_byte_query.valid) begin
                query_data <= stb;
            end
        end
    end

    // Power-on clear flag: persistent, defaults to keep enables
    always_ff @(posedge core_clk) begin
        if (rst) begin
            power_on_clear_flag <= `SRSB_PSC_RST;
        end else if (power_on_clear_command) begin
            power_on_clear_flag <= power_on_clear_value;
        end
    end

    // Request enable register; power-up load beats a host write
    always_ff @(posedge core_clk) begin
        if (rst) begin
            request_enable_q <= `SRSB_SRE_RST;
        end else if (pwr_q == SRSB_LOAD) begin
            request_enable_q <= power_on_clear_flag ? 8'h00
                : kept_q[39:32];
        end else if (request_enable_command.valid &&
                     request_enable_command.single) begin
            request_enable_q[request_enable_command.idx] <=
                request_enable_command.bit_val;
        end else if (request_enable_command.valid) begin
            request_enable_q <= request_enable_command.value;
        end
    end

    // Enables gathered for saving at power-down
    assign live_en = '{proc_en: proc_reg.en, err_en: err_reg.en,
        gauge_en: gauge_reg.en, event_en: event_reg.en};

    srsb_keep #(.WIDTH(40)) u_keep (
        .core_clk(core_clk),
        .rst(rst),
        .save(power_down && !power_on_clear_flag),
        .save_val({request_enable_q, live_en}),
        .kept_q(kept_q)
    );

    // Power sequencing: power-up loads one cycle, then settles
    always_ff @(posedge core_clk) begin
        if (rst) begin
            pwr_q <= SRSB_RUN;
        end else begin
            case (pwr_q)
                SRSB_RUN: begin
                    if (power_up) begin
                        pwr_q <= SRSB_LOAD;
                    end
                end
                SRSB_LOAD: begin
                    pwr_q <= SRSB_SETTLE;
                end
                SRSB_SETTLE: begin
                    pwr_q <= SRSB_RUN;
                end
                default: begin
                    pwr_q <= SRSB_RUN;
                end
            endcase
        end
    end

    // Clear strobe and enable load toward the lower registers
    always_ff @(posedge core_clk) begin
        if (rst) begin
            status_clear_q <= 1'b0;
            en_load_q <= 1'b0;
            en_load_val_q <= '0;
        end else begin
            status_clear_q <= clear_status_command
                || (pwr_q == SRSB_LOAD);
            en_load_q <= (pwr_q == SRSB_LOAD);
            if (pwr_q == SRSB_LOAD) begin
                en_load_val_q <= power_on_clear_flag ? '0 : kept_q[31:0];
            end
        end
    end
    assign status_clear = status_clear_q;
    assign en_load = en_load_q;
    assign en_load_val = en_load_val_q;

    // Checks
    sequence s_request;
        new_request;
    endsequence
    // A request arriving with the first poll re-arms it, so exclude that
    sequence s_poll_then_poll;
        (serial_poll && !new_request) ##1 serial_poll;
    endsequence

    a_query_whole: assert property (@(posedge core_clk) disable iff (rst)
        status_byte_query.valid && !status_byte_query.single
        |=> query_valid && query_data == $past(stb))
        else $error("whole-byte query answer wrong");
    a_query_single: assert property (@(posedge core_clk) disable iff (rst)
        status_byte_query.valid && status_byte_query.single
        |=> query_data[7:1] == 7'h00 && query_data[0] ==
            $past(stb[status_byte_query.idx]))
        else $error("single-bit query answer wrong");
    a_sum_bits: assert property (@(posedge core_clk) disable iff (rst)
        status_byte_query.valid && !status_byte_query.single |=>
        query_data[0] == $past(|(proc_reg.stat & proc_reg.en)) &&
        query_data[1] == $past(|(err_reg.stat & err_reg.en)) &&
        query_data[2] == $past(|(gauge_reg.stat & gauge_reg.en)) &&
        query_data[5] == $past(|(event_reg.stat & event_reg.en)))
        else $error("summary bit does not follow its register");
    a_mav_idle: assert property (@(posedge core_clk) disable iff (rst)
        serial_poll |=> poll_data[4] == $past(out_buf_has_data)
            && poll_data[7] == !$past(cmd_busy))
        else $error("buffer or idle bit wrong in poll answer");
    a_query_srq: assert property (@(posedge core_clk) disable iff (rst)
        status_byte_query.valid && !status_byte_query.single |=>
        query_data[6] == $past(|(stb & request_enable_q & 8'hbf)))
        else $error("queried request bit wrong");
    a_byte_stable: assert property (@(posedge core_clk) disable iff (rst)
        status_byte_query.valid && $stable(proc_reg) && $stable(err_reg)
        && $stable(gauge_reg) && $stable(event_reg)
        && $stable(out_buf_has_data) && $stable(cmd_busy)
        && $stable(request_enable_q) |-> $stable(stb))
        else $error("status byte moved without a cause");
    a_single_req: assert property (@(posedge core_clk) disable iff (rst)
        $rose(srq_pending) |-> $past(new_request)
        ##0 (!new_request || enabled_bits != $past(enabled_bits)))
        else $error("request raised without a rising enabled bit");
    a_poll_clears: assert property (@(posedge core_clk) disable iff (rst)
        s_poll_then_poll |=> poll_valid && !poll_data[6])
        else $error("second poll still shows the request");
    a_poll_first: assert property (@(posedge core_clk) disable iff (rst)
        s_request ##1 serial_poll |=> poll_data[6])
        else $error("first poll after request misses it");
    a_cls_keeps: assert property (@(posedge core_clk) disable iff (rst)
        clear_status_command && !request_enable_command.valid
        && pwr_q == SRSB_RUN |=> status_clear
        && $stable(request_enable_q))
        else $error("clear-status touched the enable register");
    a_bit3_zero: assert property (@(posedge core_clk) disable iff (rst)
        !stb[3] && !poll_data[3] && !(query_valid && query_data[3]
            && !$past(status_byte_query.single)))
        else $error("unused bit 3 is set");
    a_psc_reset: assert property (@(posedge core_clk)
        rst |=> !power_on_clear_flag)
        else $error("power-on clear flag not zero after reset");
    a_restore: assert property (@(posedge core_clk) disable iff (rst)
        power_up && pwr_q == SRSB_RUN && !power_on_clear_flag
        && !power_on_clear_command |-> ##2 en_load && status_clear
        && en_load_val == $past(kept_q[31:0], 1))
        else $error("enables not restored at power-up");
endmodule

/* tb/srsb_lower_model.sv */
// Lower status registers with enables, cleared and reloaded by the block
`timescale 1ns/1ps
module srsb_lower_model (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Host writes and reads
    input wire logic wr,
    input wire logic rd,
    input wire logic [1:0] sel,
    input wire srsb_pkg::srsb_word_t wr_stat,
    input wire srsb_pkg::srsb_word_t wr_en,
    // Controls from the block
    input wire logic status_clear,
    input wire logic en_load,
    input wire srsb_pkg::srsb_en_set_s en_load_val,
    // Registers toward the block
    output srsb_pkg::srsb_lower_s lower [4]
);
    import srsb_pkg::*;
    srsb_word_t stat_q [4];
    srsb_word_t en_q [4];
    // Host read empties the register, so the summary bit drops
    always_ff @(posedge core_clk) begin
        if (rst) begin
            stat_q <= '{default: '0};
        end else if (status_clear) begin
            stat_q <= '{default: '0};
        end else if (wr) begin
            stat_q[sel] <= wr_stat;
        end else if (rd) begin
            stat_q[sel] <= '0;
        end
    end
    // Enables survive clear status; reload comes only from the block
    always_ff @(posedge core_clk) begin
        if (rst) begin
            en_q <= '{default: '0};
        end else if (en_load) begin
            en_q <= '{en_load_val.proc_en, en_load_val.err_en,
                en_load_val.gauge_en, en_load_val.event_en};
        end else if (wr) begin
            en_q[sel] <= wr_en;
        end
    end
    // Pack into the carrier
    always_comb begin
        for (int k = 0; k < 4; k++) begin
            lower[k] = '{stat: stat_q[k], en: en_q[k]};
        end
    end
endmodule

/* tb/srsb_top_test.sv */
// Self-checking bench for the status byte block
`timescale 1ns/1ps
`define CHK(nm, ex, sn) begin \
    checks++; \
    if ((sn) !== (ex)) begin \
        num_errors++; \
        $display("mismatch %s expected %h seen %h", nm, ex, sn); \
    end \
end
module srsb_top_test;
    import srsb_pkg::*;
    localparam int POS [4] = '{0, 1, 2, 5};
    logic core_clk, rst, out_buf_has_data, cmd_busy, wr, rd;
    logic power_on_clear_command, power_on_clear_value;
    logic clear_status_command, serial_poll, power_down, power_up;
    logic query_valid, poll_valid, srq_pending, power_on_clear_flag;
    logic status_clear, en_load;
    logic [1:0] sel;
    srsb_lower_s lower [4];
    srsb_sre_cmd_s request_enable_command;
    srsb_query_s status_byte_query;
    srsb_word_t query_data, poll_data, service_status_byte;
    srsb_word_t request_enable_q, wr_stat, wr_en, got, e;
    srsb_en_set_s en_load_val;
    logic [31:0] seed = 32'he390;
    int num_errors = 0;
    int checks = 0;
    // Reference state of the status world
    int m_stat [4];
    int m_en [4];
    int m_keep [4];
    int m_req_en, m_buf, m_busy;

    srsb_top uut (.core_clk(core_clk), .rst(rst), .proc_reg(lower[0]),
        .err_reg(lower[1]), .gauge_reg(lower[2]), .event_reg(lower[3]),
        .out_buf_has_data(out_buf_has_data), .cmd_busy(cmd_busy),
        .request_enable_command(request_enable_command),
        .power_on_clear_command(power_on_clear_command),
        .power_on_clear_value(power_on_clear_value),
        .clear_status_command(clear_status_command),
        .status_byte_query(status_byte_query), .serial_poll(serial_poll),
        .power_down(power_down), .power_up(power_up),
        .query_data(query_data), .query_valid(query_valid),
        .poll_data(poll_data), .poll_valid(poll_valid),
        .srq_pending(srq_pending), .service_status_byte(service_status_byte),
        .request_enable_q(request_enable_q),
        .power_on_clear_flag(power_on_clear_flag),
        .status_clear(status_clear), .en_load(en_load),
        .en_load_val(en_load_val));
    srsb_lower_model partner (.core_clk(core_clk), .rst(rst), .wr(wr),
        .rd(rd), .sel(sel), .wr_stat(wr_stat), .wr_en(wr_en),
        .status_clear(status_clear), .en_load(en_load),
        .en_load_val(en_load_val), .lower(lower));

    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        s = s ^ (s << 5);
        return s;
    endfunction

    // Byte as the rules define it, bit 6 in its query meaning
    function automatic srsb_word_t exp_byte();
        srsb_word_t b;
        b = '0;
        for (int k = 0; k < 4; k++) begin
            b[POS[k]] = ((m_stat[k] & m_en[k]) != 0);
        end
        b[4] = m_buf[0];
        b[7] = !m_busy[0];
        b[6] = |(b & m_req_en[7:0] & 8'hbf);
        return b;
    endfunction

    task automatic end_of_test();
        $display("checks %0d num_errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
    endtask

    // One-cycle command pulse: 0 clear, 1 flag, 2 poll, 3 down, 4 up
    task automatic strobe(input int w);
        @(posedge core_clk);
        case (w)
            0: clear_status_command <= 1'b1;
            1: power_on_clear_command <= 1'b1;
            2: serial_poll <= 1'b1;
            3: power_down <= 1'b1;
            default: power_up <= 1'b1;
        endcase
        @(posedge core_clk);
        {clear_status_command, power_on_clear_command, serial_poll,
            power_down, power_up} <= '0;
    endtask

    task automatic set_lower(input int k, input srsb_word_t s,
        input srsb_word_t en);
        @(posedge core_clk);
        wr <= 1'b1;
        sel <= k[1:0];
        wr_stat <= s;
        wr_en <= en;
        @(posedge core_clk);
        wr <= 1'b0;
        m_stat[k] = s;
        m_en[k] = en;
    endtask

    // Host reads a lower register, which empties it
    task automatic host_read(input int k);
        @(posedge core_clk);
        rd <= 1'b1;
        sel <= k[1:0];
        @(posedge core_clk);
        rd <= 1'b0;
        m_stat[k] = 0;
    endtask

    task automatic write_req(input logic one, input srsb_idx_t idx,
        input logic bv, input srsb_word_t val);
        @(posedge core_clk);
        request_enable_command <= '{1'b1, one, idx, bv, val};
        @(posedge core_clk);
        request_enable_command <= '0;
        if (one) m_req_en[idx] = bv;
        else m_req_en = val;
    endtask

    // Bounded wait for a one-cycle answer, sampled mid-cycle
    task automatic wait_ans(input bit is_poll, output srsb_word_t v);
        bit ok;
        ok = 0;
        for (int i = 0; i < 4 && !ok; i++) begin
            @(negedge core_clk);
            ok = is_poll ? (poll_valid === 1'b1) : (query_valid === 1'b1);
        end
        if (!ok) begin
            num_errors++;
            $display("mismatch %s expected 1 seen 0", "answer wait");
            end_of_test();
        end
        v = is_poll ? poll_data : query_data;
    endtask

    task automatic ask(input logic one, input srsb_idx_t idx,
        output srsb_word_t v);
        @(posedge core_clk);
        status_byte_query <= '{1'b1, one, idx};
        @(posedge core_clk);
        status_byte_query <= '0;
        wait_ans(1'b0, v);
    endtask

    task automatic poll(output srsb_word_t v);
        strobe(2);
        wait_ans(1'b1, v);
    endtask

    // A hang is cut short here
    initial begin
        cyc(20000);
        num_errors++;
        end_of_test();
    end

    initial begin
        {rst, out_buf_has_data, cmd_busy, wr, rd, sel} = 7'h40;
        {wr_stat, wr_en, power_on_clear_value} = '0;
        {power_on_clear_command, clear_status_command, serial_poll} = '0;
        {power_down, power_up} = '0;
        request_enable_command = '0;
        status_byte_query = '0;
        m_stat = '{default: 0};
        m_en = '{default: 0};
        {m_req_en, m_buf, m_busy} = '0;
        cyc(16);
        rst <= 1'b0;
        @(negedge core_clk);
        `CHK("flag", 1'b0, power_on_clear_flag);
        `CHK("live", 8'h80, service_status_byte);
        // Random status worlds, whole and single-bit queries
        for (int n = 0; n < 16; n++) begin
            for (int k = 0; k < 4; k++) begin
                seed = xs(seed);
                set_lower(k, seed[7:0], seed[15:8]);
            end
            seed = xs(seed);
            @(posedge core_clk);
            out_buf_has_data <= seed[16];
            cmd_busy <= seed[17];
            m_buf = seed[16];
            m_busy = seed[17];
            write_req(1'b0, 3'h0, 1'b0, seed[7:0] & 8'hbf);
            ask(1'b0, 3'h0, got);
            `CHK("whole", exp_byte(), got);
            ask(1'b1, n[2:0], got);
            e = exp_byte();
            `CHK("single", {7'h0, e[n[2:0]]}, got);
            ask(1'b0, 3'h0, got);
            `CHK("again", exp_byte(), got);
            `CHK("live", exp_byte(), service_status_byte);
        end
        // Clear status keeps enables and drops a pending request
        e = m_en[0][7:0];
        strobe(0);
        m_stat = '{default: 0};
        cyc(2);
        `CHK("en kept", e, lower[0].en);
        `CHK("srq", 1'b0, srq_pending);
        write_req(1'b0, 3'h0, 1'b0, 8'h00);
        write_req(1'b1, 3'h0, 1'b1, 8'h00);
        @(negedge core_clk);
        `CHK("req en", 8'h01, request_enable_q);
        set_lower(0, 8'h04, 8'h04);
        cyc(3);
        `CHK("srq", 1'b1, srq_pending);
        poll(got);
        `CHK("poll", exp_byte(), got);
        `CHK("srq", 1'b0, srq_pending);
        cyc(3);
        poll(got);
        `CHK("poll", exp_byte() & 8'hbf, got);
        ask(1'b0, 3'h0, got);
        `CHK("query", exp_byte(), got);
        host_read(0);
        cyc(2);
        `CHK("live", exp_byte(), service_status_byte);
        set_lower(0, 8'h04, 8'h04);
        cyc(3);
        `CHK("srq", 1'b1, srq_pending);
        // Poll right after a fresh request, then again at once
        host_read(0);
        set_lower(0, 8'h04, 8'h04);
        @(posedge core_clk);
        serial_poll <= 1'b1;
        wait_ans(1'b1, got);
        `CHK("poll", exp_byte(), got);
        @(posedge core_clk);
        serial_poll <= 1'b0;
        @(negedge core_clk);
        `CHK("poll", exp_byte() & 8'hbf, poll_data);
        // Power cycle with retention, then with clearing
        for (int k = 0; k < 4; k++) begin
            set_lower(k, 8'h00, 8'h30 | k[7:0]);
            m_keep[k] = m_en[k];
        end
        write_req(1'b0, 3'h0, 1'b0, 8'h25);
        strobe(3);
        for (int k = 0; k < 4; k++) set_lower(k, 8'h0f, 8'h00);
        write_req(1'b0, 3'h0, 1'b0, 8'h00);
        strobe(4);
        cyc(5);
        @(negedge core_clk);
        `CHK("req en", 8'h25, request_enable_q);
        for (int k = 0; k < 4; k++) `CHK("en", m_keep[k][7:0], lower[k].en);
        `CHK("stat", 8'h00, lower[0].stat | lower[3].stat);
        m_stat = '{default: 0};
        m_en = m_keep;
        m_req_en = 8'h25;
        poll(got);
        `CHK("poll", exp_byte() & 8'hbf, got);
        set_lower(0, 8'h10, 8'h30);
        cyc(3);
        `CHK("srq", 1'b1, srq_pending);
        @(posedge core_clk);
        power_on_clear_value <= 1'b1;
        strobe(1);
        strobe(3);
        strobe(4);
        cyc(5);
        @(negedge core_clk);
        `CHK("flag", 1'b1, power_on_clear_flag);
        `CHK("req en", 8'h00, request_enable_q);
        for (int k = 0; k < 4; k++) `CHK("en", 8'h00, lower[k].en);
        end_of_test();
    end
endmodule
